// ===== rts_defines.svh
// register map, field positions, reset values and timing figures of the reset sequencer
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH

`define RTS_ADR_CAUSE      8'h00
`define RTS_ADR_STATUS     8'h04
`define RTS_ADR_CONFIG     8'h08
`define RTS_ADR_IRQ_STAT   8'h0c
`define RTS_ADR_IRQ_MASK   8'h10
`define RTS_ADR_SEQ        8'h14

`define RTS_CAUSE_BOR_BIT  0
`define RTS_CAUSE_POR_BIT  1
`define RTS_ST_PD_BIT      3
`define RTS_ST_TO_BIT      4
`define RTS_ST_UP_LSB      5
`define RTS_ST_UP_MSB      7
`define RTS_ST_UP_RESET    3'h0
`define RTS_CFG_MODE_LSB   0
`define RTS_CFG_MODE_MSB   1
`define RTS_CFG_POWER_UP_DELAY_TIMER_N_BIT 2
`define RTS_CFG_BODEN_BIT  3
`define RTS_CFG_MODE_RESET 2'h1
`define RTS_CFG_POWER_UP_DELAY_TIMER_RESET 1'b0
`define RTS_CFG_BODEN_RST  1'b1

`define RTS_OSC_LP         2'h0
`define RTS_OSC_XT         2'h1
`define RTS_OSC_HS         2'h2
`define RTS_OSC_RC         2'h3

`define RTS_IRQ_W          4
`define RTS_IRQ_RELEASE    0
`define RTS_IRQ_BROWNOUT   1
`define RTS_IRQ_WDT_RESET  2
`define RTS_IRQ_WAKE       3

`define RTS_CLK_KHZ        100000
`define RTS_POWER_UP_DELAY_TIMER_MS        72
`define RTS_OST_CYCLES     1024
`define RTS_PC_RESET       'h000
`define RTS_PC_VECTOR      'h004

`endif

// ===== rts_pkg.sv
// types shared by the reset sequencer modules
// assumes nothing beyond the defines header
package rts_pkg;
  typedef enum logic [2:0] {
    ST_POR,
    ST_BOR,
    ST_POWER_UP_DELAY_TIMER,
    ST_OST,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } rts_state_e;
  typedef logic [1:0] rts_osc_t;
endpackage

// ===== rts_sync.sv
// two-flop synchroniser for a level from outside the clock domain
// assumes the level is slow compared with clk_i
`timescale 1ns/1ps
module rts_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;
  logic q_ff;

  // meta_ff feeds q_ff only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule

// ===== rts_delay_cnt.sv
// down counter for the power-up delay and oscillator start-up counts
// assumes start_i is a one-cycle pulse and len_i is at least one
`timescale 1ns/1ps
module rts_delay_cnt #(
  parameter int unsigned CNT_W = 23
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  busy_o,
  output logic                  done_o
);
  logic [CNT_W-1:0] count_ff;
  logic             done_ff;
  logic [CNT_W-1:0] nxt_count;
  logic             nxt_done;

  // a new start reloads even mid-count
  assign nxt_count = start_i ? len_i : ((count_ff != '0) ? count_ff - 1'b1 : count_ff);
  assign nxt_done  = !start_i && (count_ff == CNT_W'(1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
    end else if (ce_i) begin
      count_ff <= nxt_count;
      done_ff  <= nxt_done;
    end
  end

  assign busy_o = (count_ff != '0);
  assign done_o = done_ff;
endmodule

// ===== rts_reset_timeout_sequencer.sv
// reset time-out sequencer and reset-cause recorder, wishbone register slave
// assumes watchdog, wake and sleep inputs come from logic on clk_i; pin and brown-out inputs are asynchronous
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "rts_defines.svh"
module rts_reset_timeout_sequencer
  import rts_pkg::*;
#(
  parameter int unsigned PC_W        = 13,
  parameter int unsigned CNT_W       = 23,
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `RTS_POWER_UP_DELAY_TIMER_MS * `RTS_CLK_KHZ,
  parameter int unsigned OST_CYCLES  = `RTS_OST_CYCLES
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic                 wb_ack_o,
  output logic [31:0]          wb_dat_o,
  input  wire logic            master_clear_pin_n_i,
  input  wire logic            brownout_detect_i,
  input  wire logic            watchdog_timeout_i,
  input  wire logic            irq_wake_i,
  input  wire logic            sleep_i,
  input  wire logic            global_interrupt_enable_i,
  input  wire logic [PC_W-1:0] pc_i,
  output logic                 core_reset_o,
  output logic                 core_stall_o,
  output logic                 pc_load_o,
  output logic [PC_W-1:0]      pc_value_o,
  output logic                 watchdog_timeout_flag_o,
  output logic                 powerdown_flag_o,
  output logic                 irq_o
);

  if (PC_W < 3 || PC_W > 24 || CNT_W > 31 || POWER_UP_DELAY_TIMER_CYCLES < 1 || OST_CYCLES < 1 ||
      64'(POWER_UP_DELAY_TIMER_CYCLES) >= (64'h1 << CNT_W) || 64'(OST_CYCLES) >= (64'h1 << CNT_W)) begin : g_chk
    $error("rts: parameters out of range");
  end

  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc);
    return pc + 1'b1;
  endfunction

  rts_state_e             state_ff;
  rts_state_e             nxt_state;
  logic                   por_flag_ff;
  logic                   bor_flag_ff;
  logic                   to_ff;
  logic                   pd_ff;
  logic [2:0]             upper_ff;
  rts_osc_t               osc_mode_ff;
  logic                   power_up_delay_timer_en_n_ff;
  logic                   boden_ff;
  logic [`RTS_IRQ_W-1:0]  irq_st_ff;
  logic [`RTS_IRQ_W-1:0]  irq_mask_ff;
  logic                   irq_ff;
  logic                   ack_ff;
  logic [31:0]            dat_ff;
  logic                   core_reset_ff;
  logic                   core_stall_ff;
  logic                   pc_load_ff;
  logic [PC_W-1:0]        pc_value_ff;
  logic                   master_clear_pin_prev_ff;

  logic                   nxt_por;
  logic                   nxt_bor;
  logic                   nxt_to;
  logic                   nxt_pd;
  logic [2:0]             nxt_upper;
  logic                   nxt_pc_load;
  logic [PC_W-1:0]        nxt_pc_value;
  logic                   nxt_core_reset;
  logic [`RTS_IRQ_W-1:0]  nxt_irq_st;
  logic [`RTS_IRQ_W-1:0]  nxt_irq_mask;
  logic [`RTS_IRQ_W-1:0]  irq_ev;
  logic                   start_power_up_delay_timer;
  logic                   start_ost;

  logic                   master_clear_pin_n_s;
  logic                   bor_s;
  logic                   power_up_delay_timer_busy;
  logic                   power_up_delay_timer_done;
  logic                   ost_done;

  rts_sync #(.RST_VAL(1'b1)) u_sync_master_clear_pin (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (master_clear_pin_n_i),
    .q_o   (master_clear_pin_n_s)
  );

  rts_sync #(.RST_VAL(1'b0)) u_sync_bor (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (brownout_detect_i),
    .q_o   (bor_s)
  );

  rts_delay_cnt #(.CNT_W(CNT_W)) u_power_up_delay_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (start_power_up_delay_timer),
    .len_i   (CNT_W'(POWER_UP_DELAY_TIMER_CYCLES)),
    .busy_o  (power_up_delay_timer_busy),
    .done_o  (power_up_delay_timer_done)
  );

  rts_delay_cnt #(.CNT_W(CNT_W)) u_ost (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (start_ost),
    .len_i   (CNT_W'(OST_CYCLES)),
    .busy_o  (),
    .done_o  (ost_done)
  );

  // event decode
  wire master_clear_pin_low   = !master_clear_pin_n_s;
  wire master_clear_pin_fall  = master_clear_pin_low && !master_clear_pin_prev_ff;
  wire crystal    = (osc_mode_ff != `RTS_OSC_RC);
  wire power_up_delay_timer_on    = !power_up_delay_timer_en_n_ff || boden_ff;
  // detector ignored while disabled, so the brownout flag then means nothing
  wire bor_hold   = boden_ff && bor_s;
  wire bor_hit    = bor_hold && (state_ff != ST_BOR);
  wire in_run     = (state_ff == ST_RUN);
  wire in_sleep   = (state_ff == ST_SLEEP);
  wire quiet      = !master_clear_pin_low && !bor_hold;
  wire wdt_rst    = watchdog_timeout_i && in_run && quiet;
  wire wdt_wake   = watchdog_timeout_i && in_sleep && quiet;
  wire irq_wake   = irq_wake_i && in_sleep && quiet && !watchdog_timeout_i;
  wire sleep_go   = sleep_i && in_run && quiet && !watchdog_timeout_i;

  // bus decode
  wire wb_hit     = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wb_wr      = wb_hit && wb_we_i && wb_sel_i[0];
  wire wr_cause   = wb_wr && (wb_adr_i == `RTS_ADR_CAUSE);
  wire wr_status  = wb_wr && (wb_adr_i == `RTS_ADR_STATUS);
  wire wr_config  = wb_wr && (wb_adr_i == `RTS_ADR_CONFIG);
  wire wr_irq_st  = wb_wr && (wb_adr_i == `RTS_ADR_IRQ_STAT);
  wire wr_irq_msk = wb_wr && (wb_adr_i == `RTS_ADR_IRQ_MASK);
  wire [31:0] rd_data =
    (wb_adr_i == `RTS_ADR_CAUSE)    ? {30'h0, por_flag_ff, bor_flag_ff} :
    (wb_adr_i == `RTS_ADR_STATUS)   ? {24'h0, upper_ff, to_ff, pd_ff, 3'h0} :
    (wb_adr_i == `RTS_ADR_CONFIG)   ? {28'h0, boden_ff, power_up_delay_timer_en_n_ff, osc_mode_ff} :
    (wb_adr_i == `RTS_ADR_IRQ_STAT) ? {28'h0, irq_st_ff} :
    (wb_adr_i == `RTS_ADR_IRQ_MASK) ? {28'h0, irq_mask_ff} :
    (wb_adr_i == `RTS_ADR_SEQ)      ? {26'h0, core_stall_ff, core_reset_ff, 1'b0, state_ff} :
                                      32'h0;

  // sequencer
  always_comb begin
    nxt_state  = state_ff;
    start_power_up_delay_timer = 1'b0;
    start_ost  = 1'b0;
    if (bor_hold) begin
      nxt_state = ST_BOR;
    end else begin
      case (state_ff)
        ST_POR: begin
          if (power_up_delay_timer_on) begin
            start_power_up_delay_timer = 1'b1;
            nxt_state  = ST_POWER_UP_DELAY_TIMER;
          end else if (crystal) begin
            start_ost = 1'b1;
            nxt_state = ST_OST;
          end else begin
            nxt_state = ST_RUN;
          end
        end
        ST_BOR: begin
          // timer forced on whenever brown-out detection is on
          start_power_up_delay_timer = 1'b1;
          nxt_state  = ST_POWER_UP_DELAY_TIMER;
        end
        ST_POWER_UP_DELAY_TIMER: begin
          if (power_up_delay_timer_done && crystal) begin
            start_ost = 1'b1;
            nxt_state = ST_OST;
          end else if (power_up_delay_timer_done) begin
            nxt_state = ST_RUN;
          end
        end
        ST_OST: begin
          if (ost_done) begin
            nxt_state = ST_RUN;
          end
        end
        ST_WAKE: begin
          if (ost_done) begin
            nxt_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleep_go) begin
            nxt_state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (master_clear_pin_fall) begin
            nxt_state = ST_RUN;
          end else if ((wdt_wake || irq_wake) && crystal) begin
            start_ost = 1'b1;
            nxt_state = ST_WAKE;
          end else if (wdt_wake || irq_wake) begin
            nxt_state = ST_RUN;
          end
        end
        default: nxt_state = ST_POR;
      endcase
    end
  end

  // master_clear_pin gates the core without restarting the timers, so a late rise releases at once
  assign nxt_core_reset = master_clear_pin_low || wdt_rst || (nxt_state == ST_POR) || (nxt_state == ST_BOR) ||
                          (nxt_state == ST_POWER_UP_DELAY_TIMER) || (nxt_state == ST_OST);

  // cause and status flags; hardware events override a same-cycle software write
  always_comb begin
    nxt_por      = por_flag_ff;
    nxt_bor      = bor_flag_ff;
    nxt_to       = to_ff;
    nxt_pd       = pd_ff;
    nxt_upper    = upper_ff;
    nxt_pc_load  = 1'b0;
    nxt_pc_value = pc_value_ff;
    if (wr_cause) begin
      nxt_bor = wb_dat_i[`RTS_CAUSE_BOR_BIT];
      nxt_por = wb_dat_i[`RTS_CAUSE_POR_BIT];
    end
    if (wr_status) begin
      nxt_upper = wb_dat_i[`RTS_ST_UP_MSB:`RTS_ST_UP_LSB];
    end
    if (bor_hit) begin
      nxt_bor   = 1'b0;
      nxt_to    = 1'b1;
      nxt_pd    = 1'b1;
      nxt_upper = `RTS_ST_UP_RESET;
    end else if (master_clear_pin_fall) begin
      nxt_upper = `RTS_ST_UP_RESET;
      if (in_sleep) begin
        nxt_to = 1'b1;
        nxt_pd = 1'b0;
      end
    end else if (wdt_rst) begin
      nxt_to    = 1'b0;
      nxt_pd    = 1'b1;
      nxt_upper = `RTS_ST_UP_RESET;
    end else if (wdt_wake) begin
      nxt_to = 1'b0;
      nxt_pd = 1'b0;
    end else if (irq_wake || sleep_go) begin
      nxt_to = 1'b1;
      nxt_pd = 1'b0;
    end
    if (bor_hit || master_clear_pin_fall || wdt_rst || (state_ff == ST_POR)) begin
      nxt_pc_load  = 1'b1;
      nxt_pc_value = PC_W'(`RTS_PC_RESET);
    end else if (wdt_wake) begin
      nxt_pc_load  = 1'b1;
      nxt_pc_value = pc_step(pc_i);
    end else if (irq_wake) begin
      nxt_pc_load  = 1'b1;
      nxt_pc_value = global_interrupt_enable_i ? PC_W'(`RTS_PC_VECTOR) : pc_step(pc_i);
    end
  end

  assign irq_ev[`RTS_IRQ_RELEASE]   = core_reset_ff && !nxt_core_reset;
  assign irq_ev[`RTS_IRQ_BROWNOUT]  = bor_hit;
  assign irq_ev[`RTS_IRQ_WDT_RESET] = wdt_rst;
  assign irq_ev[`RTS_IRQ_WAKE]      = wdt_wake || irq_wake;
  // set wins over a write-one clear in the same cycle
  assign nxt_irq_st   = (irq_st_ff & ~(wr_irq_st ? wb_dat_i[`RTS_IRQ_W-1:0] : '0)) | irq_ev;
  assign nxt_irq_mask = wr_irq_msk ? wb_dat_i[`RTS_IRQ_W-1:0] : irq_mask_ff;

  // reset stands for power-on: flags take their power-on values here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= ST_POR;
      por_flag_ff  <= 1'b0;
      bor_flag_ff  <= 1'b0;
      to_ff        <= 1'b1;
      pd_ff        <= 1'b1;
      upper_ff     <= `RTS_ST_UP_RESET;
      master_clear_pin_prev_ff <= 1'b0;
    end else if (ce_i) begin
      state_ff     <= nxt_state;
      por_flag_ff  <= nxt_por;
      bor_flag_ff  <= nxt_bor;
      to_ff        <= nxt_to;
      pd_ff        <= nxt_pd;
      upper_ff     <= nxt_upper;
      master_clear_pin_prev_ff <= master_clear_pin_low;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_mode_ff  <= `RTS_CFG_MODE_RESET;
      power_up_delay_timer_en_n_ff <= `RTS_CFG_POWER_UP_DELAY_TIMER_RESET;
      boden_ff     <= `RTS_CFG_BODEN_RST;
    end else if (ce_i && wr_config) begin
      osc_mode_ff  <= wb_dat_i[`RTS_CFG_MODE_MSB:`RTS_CFG_MODE_LSB];
      power_up_delay_timer_en_n_ff <= wb_dat_i[`RTS_CFG_POWER_UP_DELAY_TIMER_N_BIT];
      boden_ff     <= wb_dat_i[`RTS_CFG_BODEN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_ff <= 1'b1;
      core_stall_ff <= 1'b0;
      pc_load_ff    <= 1'b0;
      pc_value_ff   <= PC_W'(`RTS_PC_RESET);
      irq_st_ff     <= '0;
      irq_mask_ff   <= '0;
      irq_ff        <= 1'b0;
    end else if (ce_i) begin
      core_reset_ff <= nxt_core_reset;
      core_stall_ff <= (nxt_state == ST_WAKE) || (nxt_state == ST_SLEEP);
      pc_load_ff    <= nxt_pc_load;
      pc_value_ff   <= nxt_pc_value;
      irq_st_ff     <= nxt_irq_st;
      irq_mask_ff   <= nxt_irq_mask;
      irq_ff        <= |(nxt_irq_st & nxt_irq_mask);
    end
  end

  // unmapped reads return zero, unmapped writes are acked and dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else if (ce_i) begin
      ack_ff <= wb_hit;
      dat_ff <= (wb_hit && !wb_we_i) ? rd_data : 32'h0;
    end
  end

  assign wb_ack_o                = ack_ff;
  assign wb_dat_o                = dat_ff;
  assign core_reset_o            = core_reset_ff;
  assign core_stall_o            = core_stall_ff;
  assign pc_load_o               = pc_load_ff;
  assign pc_value_o              = pc_value_ff;
  assign watchdog_timeout_flag_o = to_ff;
  assign powerdown_flag_o        = pd_ff;
  assign irq_o                   = irq_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ost_end;
    (state_ff == ST_OST || state_ff == ST_WAKE) && ost_done && ce_i && quiet;
  endsequence
  sequence s_bor_end;
    state_ff == ST_BOR && !bor_hold && ce_i;
  endsequence

  a_por_flags:
    assert property (state_ff == ST_POR |-> to_ff && pd_ff && !por_flag_ff && upper_ff == 3'h0 && core_reset_ff)
    else $error("power-on flags wrong");
  a_power_up_delay_timer_hold:
    assert property (state_ff == ST_POWER_UP_DELAY_TIMER |-> core_reset_ff && (power_up_delay_timer_busy || power_up_delay_timer_done))
    else $error("core not held during power-up timer");
  a_ost_release:
    assert property (s_ost_end |=> state_ff == ST_RUN && !core_reset_ff)
    else $error("no release at end of start-up count");
  a_bor_timer:
    assert property (s_bor_end |=> state_ff == ST_POWER_UP_DELAY_TIMER && power_up_delay_timer_busy && core_reset_ff)
    else $error("brown-out end did not start timer");
  a_bor_flags:
    assert property (bor_hit && ce_i |=> !bor_flag_ff && to_ff && pd_ff && state_ff == ST_BOR)
    else $error("brown-out flags wrong");
  a_wdt_reset:
    assert property (wdt_rst && ce_i |=> !to_ff && pd_ff && pc_load_ff && pc_value_ff == '0 && core_reset_ff)
    else $error("watchdog reset wrong");
  a_wake_step:
    assert property (wdt_wake && ce_i |=> pc_value_ff == pc_step($past(pc_i)) && !core_reset_ff && !to_ff && !pd_ff)
    else $error("watchdog wake wrong");
  a_irq_vector:
    assert property (irq_wake && global_interrupt_enable_i && ce_i |=>
                     pc_load_ff && pc_value_ff == PC_W'(`RTS_PC_VECTOR) && to_ff && !pd_ff)
    else $error("interrupt wake vector wrong");
  a_master_clear_pin_keep:
    assert property (master_clear_pin_fall && in_run && !bor_hold && ce_i |=>
                     to_ff == $past(to_ff) && pd_ff == $past(pd_ff) && upper_ff == 3'h0 && core_reset_ff)
    else $error("master clear in run changed flags");
  a_master_clear_pin_release:
    assert property (in_run && quiet && !watchdog_timeout_i && ce_i |=> !core_reset_ff)
    else $error("release delayed after master clear");
endmodule

// ===== tb_rts_reset_timeout_sequencer.sv
// self-checking bench for the reset time-out sequencer
// assumes 100 MHz clk_i, short timer parameters, bench drives every pin
`timescale 1ns/1ps
`include "rts_defines.svh"
module testbench import rts_pkg::*;;
  localparam int PW = 20;
  localparam int OS = 8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic        master_clear_pin_n = 1'b1, bod = 1'b0, wdt = 1'b0, iwk = 1'b0, slp = 1'b0, global_interrupt_enable = 1'b0;
  logic [12:0] pc_i = 13'h000;
  logic        core_reset_o, core_stall_o, pc_load_o, to_o, pd_o, irq_o;
  logic [12:0] pc_value_o;
  int          err_count = 0;
  int          samples_checked = 0;

  always #5 clk_i = ~clk_i;

  rts_reset_timeout_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .OST_CYCLES(OS)) i_rts_reset_timeout_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .master_clear_pin_n_i(master_clear_pin_n), .brownout_detect_i(bod), .watchdog_timeout_i(wdt),
    .irq_wake_i(iwk), .sleep_i(slp), .global_interrupt_enable_i(global_interrupt_enable), .pc_i(pc_i),
    .core_reset_o(core_reset_o), .core_stall_o(core_stall_o), .pc_load_o(pc_load_o),
    .pc_value_o(pc_value_o), .watchdog_timeout_flag_o(to_o), .powerdown_flag_o(pd_o), .irq_o(irq_o));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // request held until the rising edge that samples ack, data taken and released there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  // counts cycles until a level falls, bounded
  task automatic wfall(input logic which, output int n);
    n = 0;
    while (((which ? core_stall_o : core_reset_o) !== 1'b0) && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task automatic t_por(input logic hold);
    int n;
    @(posedge clk_i);
    rst_i <= 1'b1; master_clear_pin_n <= ~hold;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    if (hold) begin
      repeat (PW + OS + 10) @(posedge clk_i);
      chk(core_reset_o, 1'b1);
      master_clear_pin_n <= 1'b1;
      wfall(1'b0, n);
      chk(n <= 4, 1'b1);
    end else begin
      wfall(1'b0, n);
      chk(n >= PW + OS, 1'b1);
      chk(n <= PW + OS + 6, 1'b1);
    end
    chk({to_o, pd_o}, 2'b11);
    wb(1'b0, `RTS_ADR_CAUSE, 32'h0);
    chk(q[1], 1'b0);
    wb(1'b0, `RTS_ADR_STATUS, 32'h0);
    chk(q[7:3], 5'b00011);
    wb(1'b0, `RTS_ADR_CONFIG, 32'h0);
    chk(q, 32'h09);
  endtask

  // timer forced on by brown-out enable even with timer disable set
  task automatic t_bor(input logic [7:0] cfg, input int lo, input int hi);
    int n;
    wb(1'b1, `RTS_ADR_CONFIG, {24'h0, cfg});
    wb(1'b1, `RTS_ADR_CAUSE, 32'h3);
    wb(1'b0, `RTS_ADR_CAUSE, 32'h0);
    chk(q, 32'h3);
    @(posedge clk_i);
    bod <= 1'b1;
    repeat (5) @(posedge clk_i);
    bod <= 1'b0;
    wfall(1'b0, n);
    chk(n >= lo, 1'b1);
    chk(n <= hi, 1'b1);
    chk({to_o, pd_o}, 2'b11);
    chk(pc_value_o, 13'h000);
    wb(1'b0, `RTS_ADR_CAUSE, 32'h0);
    chk(q[1:0], 2'b10);
  endtask

  task automatic t_wake(input logic by_wdt, input logic g, input logic [12:0] epc, input logic [1:0] ef);
    int n;
    @(posedge clk_i);
    pc_i <= 13'h123; global_interrupt_enable <= g; slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(core_stall_o, 1'b1);
    if (by_wdt) wdt <= 1'b1;
    else iwk <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0; iwk <= 1'b0;
    wfall(1'b1, n);
    chk(n >= OS, 1'b1);
    chk(n <= OS + 4, 1'b1);
    chk(core_reset_o, 1'b0);
    chk({to_o, pd_o}, ef);
    chk(pc_value_o, epc);
  endtask

  // masked event still latches status, but keeps the line low
  task automatic t_wdt(input logic [3:0] msk);
    wb(1'b1, `RTS_ADR_IRQ_MASK, {28'h0, msk});
    @(posedge clk_i);
    wdt <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0;
    @(negedge clk_i);
    chk(pc_load_o, 1'b1);
    chk(core_reset_o, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(core_reset_o, 1'b0);
    chk({to_o, pd_o}, 2'b01);
    chk(pc_value_o, 13'h000);
    chk(irq_o, msk[2]);
    wb(1'b0, `RTS_ADR_IRQ_STAT, 32'h0);
    chk(q[2], 1'b1);
    wb(1'b1, `RTS_ADR_IRQ_STAT, 32'hf);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
  endtask

  task automatic t_master_clear_pin(input logic in_sleep, input logic [1:0] ef);
    int n;
    wb(1'b1, `RTS_ADR_STATUS, 32'he0);
    @(posedge clk_i);
    slp <= in_sleep;
    @(posedge clk_i);
    slp <= 1'b0; master_clear_pin_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(core_reset_o, 1'b1);
    master_clear_pin_n <= 1'b1;
    wfall(1'b0, n);
    chk(n <= 4, 1'b1);
    chk({to_o, pd_o}, ef);
    wb(1'b0, `RTS_ADR_STATUS, 32'h0);
    chk(q[7:5], 3'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    t_por(1'b0);
    t_bor(8'h0f, PW, PW + 6);
    t_bor(8'h0d, PW + OS, PW + OS + 8);
    t_wake(1'b1, 1'b0, 13'h124, 2'b00);
    t_wake(1'b0, 1'b1, 13'h004, 2'b10);
    t_wake(1'b0, 1'b0, 13'h124, 2'b10);
    t_wdt(4'h4);
    t_wdt(4'h0);
    t_master_clear_pin(1'b0, 2'b01);
    t_master_clear_pin(1'b1, 2'b10);
    wb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    t_por(1'b1);
    end_of_test();
  end

  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule
